// file: independent_watchdog.sv
`timescale 1ns/1ns
module independent_watchdog
    import wdt_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic standby_exit_i,
    input wire logic hw_start_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic running_o,
    output logic wdt_reset_o
);
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;
    logic unlock_reg, unlock_next;
    logic run_reg, run_next;
    logic strap_reg;
    logic [2:0] div_reg, div_next;
    logic [11:0] rld_reg, rld_next;
    logic [11:0] lim_reg, lim_next;
    logic [11:0] cnt_reg, cnt_next;
    logic [7:0] pre_reg, pre_next;
    logic rst_out_reg, rst_out_next;
    logic wr, rd_req, lo_lanes;
    logic [15:0] key;
    logic cmd_unlock, cmd_refresh, cmd_start;
    logic div_wr, rld_wr, lim_wr;
    logic div_busy, rld_busy, lim_busy;
    logic lim_done;
    logic [2:0] div_cur;
    logic [11:0] rld_cur, lim_cur;
    logic [7:0] div_last;
    logic tick, early;

    // Write commits on the edge where ack is seen high
    assign wr = cyc_i & stb_i & we_i & ack_reg;
    assign rd_req = cyc_i & stb_i & ~ack_reg;
    assign lo_lanes = sel_i[0] & sel_i[1];
    assign key = dat_i[15:0];

    assign cmd_unlock = wr && adr_i == OFS_CMD && lo_lanes && key == KEY_UNLOCK;
    assign cmd_refresh = wr && adr_i == OFS_CMD && lo_lanes && key == KEY_REFRESH;
    assign cmd_start = wr && adr_i == OFS_CMD && lo_lanes && key == KEY_START;

    // Protected writes also need the matching update flag clear
    assign div_wr = wr && adr_i == OFS_DIV && sel_i[0] && unlock_reg && !div_busy;
    assign rld_wr = wr && adr_i == OFS_RLD && lo_lanes && unlock_reg && !rld_busy;
    assign lim_wr = wr && adr_i == OFS_LIM && lo_lanes && unlock_reg && !lim_busy;

    xfer_channel #(.W(3), .RST(DIV_RST)) u_div
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(div_wr),
        .data_i(dat_i[2:0]),
        .busy_o(div_busy),
        .done_o(),
        .data_o(div_cur)
    );

    xfer_channel #(.W(12), .RST(RLD_RST)) u_rld
    (
        .clk_i(clk_i),
        .rst_i(rst_i | standby_exit_i),
        .load_i(rld_wr),
        .data_i(dat_i[11:0]),
        .busy_o(rld_busy),
        .done_o(),
        .data_o(rld_cur)
    );

    xfer_channel #(.W(12), .RST(LIM_RST)) u_lim
    (
        .clk_i(clk_i),
        .rst_i(rst_i | standby_exit_i),
        .load_i(lim_wr),
        .data_i(dat_i[11:0]),
        .busy_o(lim_busy),
        .done_o(lim_done),
        .data_o(lim_cur)
    );

    // Divider code to terminal count, code 7 capped like code 6
    always_comb
    begin
        if (div_cur > DIV_CAP)
        begin
            div_last = (DIV_BASE << DIV_CAP) - 8'h01;
        end
        else
        begin
            div_last = (DIV_BASE << div_cur) - 8'h01;
        end
    end

    // At or above, so a smaller divider does not stall the count until wrap
    assign tick = run_reg && pre_reg >= div_last;
    assign early = lim_cur != LIM_OFF && cnt_reg > lim_cur;

    always_comb
    begin
        unlock_next = unlock_reg;
        run_next = run_reg | cmd_start | (strap_reg & hw_start_i);
        div_next = div_reg;
        rld_next = rld_reg;
        lim_next = lim_reg;
        pre_next = run_reg ? pre_reg + 8'h01 : 8'h00;
        cnt_next = cnt_reg;
        rst_out_next = 1'b0;
        if (wr && adr_i == OFS_CMD && lo_lanes)
        begin
            unlock_next = cmd_unlock;
        end
        if (div_wr)
        begin
            div_next = dat_i[2:0];
        end
        if (rld_wr)
        begin
            rld_next = dat_i[11:0];
        end
        if (lim_wr)
        begin
            lim_next = dat_i[11:0];
        end
        if (tick)
        begin
            pre_next = 8'h00;
        end
        if (cmd_refresh && early)
        begin
            rst_out_next = 1'b1;
            cnt_next = rld_cur;
        end
        else if (cmd_refresh || lim_done)
        begin
            cnt_next = rld_cur;
        end
        else if (tick)
        begin
            if (cnt_reg == CNT_ZERO)
            begin
                rst_out_next = 1'b1;
                cnt_next = CNT_TOP;
            end
            else
            begin
                cnt_next = cnt_reg - 12'h001;
            end
        end
        if (standby_exit_i)
        begin
            unlock_next = 1'b0;
            rld_next = RLD_RST;
            lim_next = LIM_RST;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            unlock_reg <= 1'b0;
            run_reg <= 1'b0;
            strap_reg <= 1'b1;
            div_reg <= DIV_RST;
            rld_reg <= RLD_RST;
            lim_reg <= LIM_RST;
            cnt_reg <= CNT_TOP;
            pre_reg <= 8'h00;
            rst_out_reg <= 1'b0;
        end
        else
        begin
            unlock_reg <= unlock_next;
            run_reg <= run_next;
            strap_reg <= 1'b0;
            div_reg <= div_next;
            rld_reg <= rld_next;
            lim_reg <= lim_next;
            cnt_reg <= cnt_next;
            pre_reg <= pre_next;
            rst_out_reg <= rst_out_next;
        end
    end

    // Read data is sampled at request; unmapped reads give zero
    always_comb
    begin
        ack_next = rd_req;
        rdat_next = rdat_reg;
        if (rd_req)
        begin
            rdat_next = 32'h0000_0000;
            case (adr_i)
                OFS_CMD: rdat_next = 32'h0000_0000;
                OFS_DIV: rdat_next[2:0] = div_reg;
                OFS_RLD: rdat_next[11:0] = rld_reg;
                OFS_STS:
                begin
                    rdat_next[STS_DIV] = div_busy;
                    rdat_next[STS_RLD] = rld_busy;
                    rdat_next[STS_LIM] = lim_busy;
                end
                OFS_LIM: rdat_next[11:0] = lim_cur;
                default: rdat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = rdat_reg;
    assign running_o = run_reg;
    assign wdt_reset_o = rst_out_reg;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_unlock_key: assert property (cmd_unlock |=> unlock_reg)
        else $error("unlock key did not open access");
    a_relock_key: assert property (wr && adr_i == OFS_CMD && lo_lanes && !cmd_unlock
        |=> !unlock_reg)
        else $error("protection not restored");
    a_refresh_load: assert property (cmd_refresh && !early |=> cnt_reg == $past(rld_cur))
        else $error("refresh did not load counter");
    a_start_run: assert property (cmd_start |=> running_o)
        else $error("start command ignored");
    a_cmd_reads_zero: assert property (rd_req && adr_i == OFS_CMD |=> dat_o == 32'h0)
        else $error("command register read nonzero");
    a_locked_div: assert property (!unlock_reg && !div_busy |=> !div_busy)
        else $error("divider update while locked");
    a_rld_flag_clears: assert property ($rose(rld_busy) |-> ##[1:8] !rld_busy)
        else $error("reload flag stuck");
    a_lim_flag_clears: assert property ($rose(lim_busy) |-> ##[1:8] !lim_busy)
        else $error("limit flag stuck");
    a_early_refresh: assert property (cmd_refresh && early |=> wdt_reset_o)
        else $error("early refresh did not reset");
    a_zero_reset: assert property (tick && cnt_reg == CNT_ZERO && !cmd_refresh && !lim_done
        |=> wdt_reset_o && cnt_reg == CNT_TOP)
        else $error("expiry reset missing");
    a_lim_reload: assert property (lim_done && !cmd_refresh |=> cnt_reg == $past(rld_cur))
        else $error("limit change did not reload");
    a_div_tick: assert property (tick && div_cur == 3'h7 |-> pre_reg == 8'hff)
        else $error("code 7 divisor wrong");
    a_ack_one: assert property (ack_o |=> !ack_o)
        else $error("ack held over two cycles");
    a_ack_answer: assert property (rd_req |=> ack_o)
        else $error("bus request not acknowledged");
    a_div_locked: assert property (!unlock_reg |=> div_reg == $past(div_reg))
        else $error("divider changed while locked");
    a_rld_locked: assert property (!unlock_reg && !standby_exit_i
        |=> rld_reg == $past(rld_reg))
        else $error("reload changed while locked");
    a_locked_rld: assert property (!unlock_reg && !rld_busy |=> !rld_busy)
        else $error("reload update while locked");
    a_locked_lim: assert property (!unlock_reg && !lim_busy |=> !lim_busy)
        else $error("limit update while locked");
    a_div_busy_hold: assert property (div_busy |=> div_reg == $past(div_reg))
        else $error("divider written while busy");
    a_rld_busy_hold: assert property (rld_busy && !standby_exit_i
        |=> rld_reg == $past(rld_reg))
        else $error("reload written while busy");
    a_standby_defaults: assert property (standby_exit_i
        |=> rld_reg == RLD_RST && lim_cur == LIM_RST)
        else $error("standby exit did not restore defaults");
    a_run_sticky: assert property (running_o |=> running_o)
        else $error("watchdog stopped without reset");
    a_stop_prescale: assert property (!running_o |-> pre_reg == 8'h00)
        else $error("prescaler moved while stopped");
    a_sts_idle: assert property (rd_req && adr_i == OFS_STS
        && !div_busy && !rld_busy && !lim_busy |=> dat_o == 32'h0)
        else $error("idle status read nonzero");
    a_lim_readback: assert property (rd_req && adr_i == OFS_LIM
        |=> dat_o[11:0] == $past(lim_cur))
        else $error("limit read not counter copy");
    a_div_readback: assert property (rd_req && adr_i == OFS_DIV
        |=> dat_o[2:0] == $past(div_reg))
        else $error("divider read wrong");

    c_expire: cover property (running_o && wdt_reset_o);
    c_refresh: cover property (cmd_refresh && !early);
    c_lim_change: cover property (lim_done);
    c_early: cover property (cmd_refresh && early);
    c_standby: cover property (standby_exit_i ##1 rld_reg == RLD_RST);
endmodule

// file: wdt_pkg.sv
package wdt_pkg;
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_DIV = 8'h04;
    localparam logic [7:0] OFS_RLD = 8'h08;
    localparam logic [7:0] OFS_STS = 8'h0c;
    localparam logic [7:0] OFS_LIM = 8'h10;
    localparam logic [15:0] KEY_UNLOCK = 16'h5555;
    localparam logic [15:0] KEY_REFRESH = 16'haaaa;
    localparam logic [15:0] KEY_START = 16'hcccc;
    localparam logic [11:0] CNT_TOP = 12'hfff;
    localparam logic [11:0] CNT_ZERO = 12'h000;
    localparam logic [11:0] LIM_OFF = 12'hfff;
    localparam logic [11:0] RLD_RST = 12'hfff;
    localparam logic [11:0] LIM_RST = 12'hfff;
    localparam logic [2:0] DIV_RST = 3'h0;
    localparam logic [2:0] DIV_CAP = 3'h6;
    localparam logic [7:0] DIV_BASE = 8'h04;
    localparam int STS_DIV = 0;
    localparam int STS_RLD = 1;
    localparam int STS_LIM = 2;
    localparam int CLK_NS = 10;
    localparam int XFER_NS = 40;
    localparam int XFER_CYC = (XFER_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] XFER_LAST = 4'(XFER_CYC - 1);
endpackage

// file: xfer_channel.sv
`timescale 1ns/1ns
module xfer_channel
    import wdt_pkg::*;
#(
    parameter int W = 12,
    parameter logic [W-1:0] RST = '0
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [W-1:0] data_i,
    output logic busy_o,
    output logic done_o,
    output logic [W-1:0] data_o
);
    logic busy_reg, busy_next;
    logic done_reg, done_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [W-1:0] hold_reg, hold_next;
    logic [W-1:0] out_reg, out_next;

    // Value crosses after a fixed delay, like a slow-domain handover
    always_comb
    begin
        busy_next = busy_reg;
        done_next = 1'b0;
        cnt_next = cnt_reg;
        hold_next = hold_reg;
        out_next = out_reg;
        if (load_i)
        begin
            busy_next = 1'b1;
            cnt_next = XFER_LAST;
            hold_next = data_i;
        end
        else if (busy_reg)
        begin
            if (cnt_reg == 4'h0)
            begin
                busy_next = 1'b0;
                done_next = 1'b1;
                out_next = hold_reg;
            end
            else
            begin
                cnt_next = cnt_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            cnt_reg <= 4'h0;
            hold_reg <= RST;
            out_reg <= RST;
        end
        else
        begin
            busy_reg <= busy_next;
            done_reg <= done_next;
            cnt_reg <= cnt_next;
            hold_reg <= hold_next;
            out_reg <= out_next;
        end
    end

    assign busy_o = busy_reg;
    assign done_o = done_reg;
    assign data_o = out_reg;
endmodule

// file: independent_watchdog_regs_test.sv
`timescale 1ns/1ns
module independent_watchdog_regs_test
    import wdt_pkg::*;
;
    typedef struct packed { logic w; logic [7:0] a; logic [31:0] d; } row_s;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic standby_exit_i = 1'b0;
    logic hw_start_i = 1'b0;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic running_o;
    logic wdt_reset_o;
    int err_count = 0;
    int n_compared = 0;
    int c;
    int d;
    logic [7:0] bofs [3] = '{8'h04, 8'h08, 8'h10};
    logic [31:0] bv1 [3] = '{32'h1, 32'h0a5, 32'h0c3};
    logic [31:0] bv2 [3] = '{32'h2, 32'h05a, 32'h03c};
    // Writes are followed by a pause so no update flag is still busy
    row_s table_rows [23] = '{
        '{1'b0, 8'h04, 32'h0},
        '{1'b0, 8'h08, 32'hfff},
        '{1'b0, 8'h0c, 32'h0},
        '{1'b0, 8'h10, 32'hfff},
        '{1'b1, 8'h14, 32'hffffffff},
        '{1'b0, 8'h14, 32'h0},
        '{1'b1, 8'h08, 32'h123},
        '{1'b0, 8'h08, 32'hfff},
        '{1'b1, 8'h00, 32'h5555},
        '{1'b1, 8'h08, 32'h123},
        '{1'b0, 8'h08, 32'h123},
        '{1'b1, 8'h10, 32'h800},
        '{1'b0, 8'h10, 32'h800},
        '{1'b1, 8'h00, 32'haaaa},
        '{1'b1, 8'h08, 32'h456},
        '{1'b0, 8'h08, 32'h123},
        '{1'b1, 8'h00, 32'hffff5555},
        '{1'b1, 8'h08, 32'h0ab},
        '{1'b0, 8'h08, 32'h0ab},
        '{1'b1, 8'h00, 32'h1234},
        '{1'b1, 8'h10, 32'h100},
        '{1'b0, 8'h10, 32'h800},
        '{1'b0, 8'h00, 32'h0}
    };

    always #5 clk_i = ~clk_i;

    independent_watchdog i_independent_watchdog (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .standby_exit_i(standby_exit_i),
        .hw_start_i(hw_start_i),
        .cyc_i(cyc_i),
        .stb_i(stb_i),
        .we_i(we_i),
        .adr_i(adr_i),
        .sel_i(sel_i),
        .dat_i(dat_i),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .running_o(running_o),
        .wdt_reset_o(wdt_reset_o)
    );

    task automatic stop_test();
        $display("Compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Ack is sampled before this edge's updates land, as the slave sees it
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] q);
        int k;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= wd;
        sel_i <= 4'hf;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk_i);
            if (ack_o === 1'b1)
                break;
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        if (k == 20)
        begin
            err_count++;
            $display("MISMATCH t=%0t ack got=%h exp=%h", $time, ack_o, 1'b1);
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic [31:0] q;
        wb(1'b1, a, wd, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q, e);
    endtask

    task automatic do_reset(input logic hw);
        rst_i <= 1'b1;
        hw_start_i <= hw;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // Count edges until the reset pulse; lim + 1 means none seen
    task automatic wait_pulse(input int lim, output int n);
        for (n = 1; n <= lim; n++)
        begin
            @(posedge clk_i);
            if (wdt_reset_o === 1'b1)
                break;
        end
    endtask

    initial
    begin
        do_reset(1'b0);
        foreach (table_rows[i])
        begin
            if (table_rows[i].w)
            begin
                wr(table_rows[i].a, table_rows[i].d);
                repeat (8) @(posedge clk_i);
            end
            else
            begin
                rdc(table_rows[i].a, table_rows[i].d);
            end
        end
        for (int i = 0; i < 3; i++)
        begin
            wr(OFS_CMD, 32'(KEY_UNLOCK));
            wr(bofs[i], bv1[i]);
            wr(bofs[i], bv2[i]);
            repeat (8) @(posedge clk_i);
            rdc(bofs[i], bv1[i]);
            wr(bofs[i], bv2[i]);
            rdc(OFS_STS, 32'h1 << i);
            repeat (8) @(posedge clk_i);
            rdc(OFS_STS, 32'h0);
            rdc(bofs[i], bv2[i]);
        end
        @(posedge clk_i);
        standby_exit_i <= 1'b1;
        @(posedge clk_i);
        standby_exit_i <= 1'b0;
        rdc(OFS_RLD, 32'hfff);
        rdc(OFS_LIM, 32'hfff);
        rdc(OFS_DIV, 32'h2);
        wr(OFS_RLD, 32'h0aa);
        rdc(OFS_RLD, 32'hfff);
        do_reset(1'b0);
        repeat (3) @(posedge clk_i);
        check(32'(running_o), 32'h0);
        wr(OFS_CMD, 32'(KEY_UNLOCK));
        wr(OFS_RLD, 32'h00f);
        repeat (8) @(posedge clk_i);
        wr(OFS_CMD, 32'(KEY_START));
        repeat (2) @(posedge clk_i);
        check(32'(running_o), 32'h1);
        // Prescaler phase is free, so the pulse may land up to one tick early
        for (int code = 0; code < 8; code++)
        begin
            d = (code == 7) ? 256 : (4 << code);
            wr(OFS_CMD, 32'(KEY_UNLOCK));
            wr(OFS_DIV, 32'(code));
            repeat (8) @(posedge clk_i);
            wr(OFS_CMD, 32'(KEY_REFRESH));
            wait_pulse(16 * d + 8, c);
            check(32'(c >= 15 * d && c <= 16 * d + 6), 32'h1);
        end
        wr(OFS_CMD, 32'(KEY_UNLOCK));
        wr(OFS_DIV, 32'h0);
        wr(OFS_LIM, 32'h008);
        repeat (8) @(posedge clk_i);
        wr(OFS_CMD, 32'(KEY_REFRESH));
        wait_pulse(4, c);
        check(32'(c <= 4), 32'h1);
        repeat (36) @(posedge clk_i);
        wr(OFS_CMD, 32'(KEY_REFRESH));
        wait_pulse(20, c);
        check(32'(c), 32'd21);
        do_reset(1'b1);
        repeat (3) @(posedge clk_i);
        check(32'(running_o), 32'h1);
        stop_test();
    end
endmodule
